// ==== pkg/uif_pkg.sv ====
// constants for the interrupt, status and fifo setup block
package uif_pkg;
   // ======================================================
   // register port offsets
   localparam logic [2:0] A_DATA = 3'h0;
   localparam logic [2:0] A_MASK = 3'h1;
   localparam logic [2:0] A_ISR  = 3'h2;
   localparam logic [2:0] A_LSR  = 3'h5;
   localparam logic [2:0] A_MSR  = 3'h6;
   // ======================================================
   // fifo_setup fields
   localparam int FS_EN    = 0;
   localparam int FS_RXRST = 1;
   localparam int FS_TXRST = 2;
   localparam int FS_DMA   = 3;
   localparam int FS_TRIG  = 6;
   // ======================================================
   // interrupt_mask fields and reset value
   localparam int M_RXD   = 0;
   localparam int M_TX    = 1;
   localparam int M_LSR   = 2;
   localparam int M_MSR   = 3;
   localparam int M_SLEEP = 4;
   localparam int M_XOFF  = 5;
   localparam int M_RTS   = 6;
   localparam int M_CTS   = 7;
   localparam logic [7:0] MASK_RST = 8'h00;
   // ======================================================
   // source codes, highest priority first
   localparam logic [5:0] C_LSR  = 6'h06;
   localparam logic [5:0] C_TO   = 6'h0C;
   localparam logic [5:0] C_RXD  = 6'h04;
   localparam logic [5:0] C_TX   = 6'h02;
   localparam logic [5:0] C_MSR  = 6'h00;
   localparam logic [5:0] C_XS   = 6'h10;
   localparam logic [5:0] C_FLOW = 6'h20;
   localparam logic [5:0] C_NONE = 6'h01;
   // ======================================================
   // fifo geometry and trigger levels
   localparam int DEPTH = 16;
   localparam int ENT_W = 11;
   localparam logic [4:0] FULL_LVL = 5'h10;
   localparam logic [4:0] TRIG_0 = 5'h01;
   localparam logic [4:0] TRIG_1 = 5'h04;
   localparam logic [4:0] TRIG_2 = 5'h08;
   localparam logic [4:0] TRIG_3 = 5'h0E;
   // ======================================================
   // receive time-out, in bit ticks
   localparam int CHAR_BITS = 10;
   localparam int TO_CHARS  = 4;
   localparam int TO_XBITS  = 12;
   localparam logic [5:0] TO_BITS =
      6'(TO_CHARS * CHAR_BITS + TO_XBITS);
endpackage : uif_pkg

// ==== rtl/uif_core.sv ====
// interrupt mask, source status, line status and fifo setup of one channel
`timescale 1ns/1ps
`default_nettype none
module uif_core (
   input  wire logic       i_clock,
   input  wire logic       i_rst_b,
   input  wire logic [2:0] i_addr,
   input  wire logic       i_rd,
   input  wire logic       i_wr,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata,
   output logic            o_int,
   input  wire logic       i_enh_unlock,
   input  wire logic       i_auto_cts_en,
   input  wire logic       i_auto_rts_en,
   input  wire logic       i_rx_valid,
   input  wire logic [7:0] i_rx_data,
   input  wire logic [2:0] i_rx_err,
   output logic            o_rx_ready,
   input  wire logic       i_rx_overrun,
   input  wire logic       i_bit_tick,
   input  wire logic       i_tx_empty,
   input  wire logic       i_tx_full,
   input  wire logic       i_tsr_empty,
   output logic            o_tx_wstrobe,
   output logic      [7:0] o_tx_wdata,
   output logic            o_tx_fifo_reset,
   input  wire logic [7:0] i_modem_status,
   output logic            o_msr_read,
   input  wire logic       i_xoff_hit,
   input  wire logic       i_xon_hit,
   input  wire logic       i_special_hit,
   input  wire logic       i_rts_n,
   input  wire logic       i_cts_n_pin,
   output logic            o_sleep_en,
   output logic            o_rx_ready_pin_n,
   output logic            o_tx_ready_pin_n
);
   // ======================================================
   // host access decode
   logic                   rd_data, rd_isr, rd_lsr, rd_msr;
   logic                   wr_data, wr_mask, wr_fs;
   assign rd_data = i_rd && (i_addr == uif_pkg::A_DATA);
   assign rd_isr  = i_rd && (i_addr == uif_pkg::A_ISR);
   assign rd_lsr  = i_rd && (i_addr == uif_pkg::A_LSR);
   assign rd_msr  = i_rd && (i_addr == uif_pkg::A_MSR);
   assign wr_data = i_wr && (i_addr == uif_pkg::A_DATA);
   assign wr_mask = i_wr && (i_addr == uif_pkg::A_MASK);
   assign wr_fs   = i_wr && (i_addr == uif_pkg::A_ISR);

   // ======================================================
   // interrupt_mask
   logic [7:0]             mask_reg;
   logic [7:0]             emask;
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) mask_reg <= uif_pkg::MASK_RST;
      else if (wr_mask) mask_reg <= i_wdata;
   end
   assign emask = i_enh_unlock ? mask_reg : {4'h0, mask_reg[3:0]};

   // ======================================================
   // fifo_setup
   logic                   fen_reg, dma_reg, rx_rst;
   logic [1:0]             trig_reg;
   logic [4:0]             trig;
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         fen_reg  <= 1'b0;
         dma_reg  <= 1'b0;
         trig_reg <= 2'b00;
      end else if (wr_fs && i_wdata[uif_pkg::FS_EN]) begin
         fen_reg  <= 1'b1;
         dma_reg  <= i_wdata[uif_pkg::FS_DMA];
         trig_reg <= i_wdata[uif_pkg::FS_TRIG +: 2];
      end else if (wr_fs) begin
         fen_reg  <= 1'b0;
      end
   end
   assign rx_rst = wr_fs && i_wdata[uif_pkg::FS_EN]
                   && i_wdata[uif_pkg::FS_RXRST];
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) o_tx_fifo_reset <= 1'b0;
      else o_tx_fifo_reset <= wr_fs && i_wdata[uif_pkg::FS_EN]
                              && i_wdata[uif_pkg::FS_TXRST];
   end
   always_comb begin
      case (trig_reg)
         2'b00:   trig = uif_pkg::TRIG_0;
         2'b01:   trig = uif_pkg::TRIG_1;
         2'b10:   trig = uif_pkg::TRIG_2;
         2'b11:   trig = uif_pkg::TRIG_3;
         default: trig = uif_pkg::TRIG_0;
      endcase
   end

   // ======================================================
   // two-entry buffer in front of the receive fifo
   logic [uif_pkg::ENT_W-1:0] buf_mem [2];
   logic                   buf_wp, buf_rp, buf_in, buf_out, room;
   logic [1:0]             buf_cnt, buf_cnt_next;
   logic [4:0]             cnt;
   assign buf_in  = i_rx_valid && o_rx_ready;
   // without fifos the holding register takes one character only
   assign room    = fen_reg ? (cnt < uif_pkg::FULL_LVL) : (cnt == 5'h00);
   assign buf_out = (buf_cnt != 2'b00) && room;
   assign buf_cnt_next = buf_cnt + {1'b0, buf_in} - {1'b0, buf_out};
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         buf_wp     <= 1'b0;
         buf_rp     <= 1'b0;
         buf_cnt    <= 2'b00;
         o_rx_ready <= 1'b0;
      end else begin
         buf_wp     <= buf_wp ^ buf_in;
         buf_rp     <= buf_rp ^ buf_out;
         buf_cnt    <= buf_cnt_next;
         o_rx_ready <= buf_cnt_next != 2'b10;
      end
   end
   always_ff @(posedge i_clock) begin
      if (buf_in) buf_mem[buf_wp] <= {i_rx_err, i_rx_data};
   end

   // ======================================================
   // receive fifo with error tags
   logic [uif_pkg::ENT_W-1:0] fifo_mem [uif_pkg::DEPTH];
   logic [uif_pkg::ENT_W-1:0] head, pdat;
   logic [3:0]             wp, rp;
   logic [4:0]             err_cnt;
   logic                   push, pop, perr, herr;
   assign push = buf_out;
   assign pdat = buf_mem[buf_rp];
   assign perr = |pdat[10:8];
   assign pop  = rd_data && (cnt != 5'h00);
   assign head = fifo_mem[rp];
   assign herr = |head[10:8];
   always_ff @(posedge i_clock) begin
      if (!i_rst_b || rx_rst) begin
         wp      <= 4'h0;
         rp      <= 4'h0;
         cnt     <= 5'h00;
         err_cnt <= 5'h00;
      end else begin
         wp      <= wp + 4'(push);
         rp      <= rp + 4'(pop);
         cnt     <= cnt + 5'(push) - 5'(pop);
         err_cnt <= err_cnt + 5'(push && perr) - 5'(pop && herr);
      end
   end
   always_ff @(posedge i_clock) begin
      if (push) fifo_mem[wp] <= pdat;
   end

   // ======================================================
   // line status
   logic                   ovr_reg;
   logic [7:0]             lsr_val;
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) ovr_reg <= 1'b0;
      else if (i_rx_overrun) ovr_reg <= 1'b1;
      else if (rd_lsr) ovr_reg <= 1'b0;
   end
   assign lsr_val = {err_cnt != 5'h00, i_tx_empty && i_tsr_empty,
                     i_tx_empty, (cnt != 5'h00) ? head[10:8] : 3'b000,
                     ovr_reg, cnt != 5'h00};

   // ======================================================
   // interrupt sources
   logic                   lsr_int_reg, to_flag_reg, tx_int_reg;
   logic                   xoff_reg, spec_reg, flow_reg, tx_empty_d;
   logic                   to_run, tx_set, cts_s1, cts_s2, cts_d, rts_d;
   logic                   src_lsr, src_to, src_rxd, src_tx, src_msr;
   logic                   src_xs, src_fl;
   logic [5:0]             to_cnt;
   // overrun now, errors on read out
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) lsr_int_reg <= 1'b0;
      else if (i_rx_overrun || (pop && herr)) lsr_int_reg <= 1'b1;
      else if (rd_lsr) lsr_int_reg <= 1'b0;
   end
   assign to_run = fen_reg && (cnt != 5'h00) && (cnt < trig);
   always_ff @(posedge i_clock) begin
      if (!i_rst_b || push || pop || !to_run) to_cnt <= 6'h00;
      else if (i_bit_tick && to_cnt != uif_pkg::TO_BITS)
         to_cnt <= to_cnt + 6'h01;
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_b || rx_rst) to_flag_reg <= 1'b0;
      else if (to_run && !pop && to_cnt == uif_pkg::TO_BITS)
         to_flag_reg <= 1'b1;
      else if (pop) to_flag_reg <= 1'b0;
   end
   // empty edge or arming while empty
   // edge only counts while enabled, so a stale flag never fires on arming
   assign tx_set = (i_tx_empty && !tx_empty_d && mask_reg[uif_pkg::M_TX])
                   || (wr_mask && i_wdata[uif_pkg::M_TX]
                   && !mask_reg[uif_pkg::M_TX] && i_tx_empty);
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         tx_int_reg <= 1'b0;
         // idle level of an empty fifo, no false edge after reset
         tx_empty_d <= 1'b1;
      end else begin
         tx_empty_d <= i_tx_empty;
         if (tx_set) tx_int_reg <= 1'b1;
         else if (rd_isr || wr_data) tx_int_reg <= 1'b0;
      end
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         xoff_reg <= 1'b0;
         spec_reg <= 1'b0;
      end else begin
         if (i_xoff_hit) xoff_reg <= 1'b1;
         else if (rd_isr || i_xon_hit) xoff_reg <= 1'b0;
         if (i_special_hit) spec_reg <= 1'b1;
         else if (rd_isr || buf_in) spec_reg <= 1'b0;
      end
   end
   // pin input passes two flops before the edge detector
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         cts_s1 <= 1'b1;
         cts_s2 <= 1'b1;
         cts_d  <= 1'b1;
         rts_d  <= 1'b1;
      end else begin
         cts_s1 <= i_cts_n_pin;
         cts_s2 <= cts_s1;
         cts_d  <= cts_s2;
         rts_d  <= i_rts_n;
      end
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) flow_reg <= 1'b0;
      else if ((i_auto_cts_en && emask[uif_pkg::M_CTS] && cts_s2 && !cts_d)
               || (i_auto_rts_en && emask[uif_pkg::M_RTS]
                   && i_rts_n && !rts_d))
         flow_reg <= 1'b1;
      else if (rd_msr) flow_reg <= 1'b0;
   end

   assign src_lsr = lsr_int_reg && emask[uif_pkg::M_LSR];
   assign src_to  = to_flag_reg && emask[uif_pkg::M_RXD];
   assign src_rxd = emask[uif_pkg::M_RXD]
                    && (fen_reg ? (cnt >= trig) : (cnt != 5'h00));
   assign src_tx  = tx_int_reg && emask[uif_pkg::M_TX];
   assign src_msr = emask[uif_pkg::M_MSR] && (|i_modem_status[3:0]);
   assign src_xs  = emask[uif_pkg::M_XOFF] && (xoff_reg || spec_reg);
   assign src_fl  = flow_reg && i_enh_unlock;

   // ======================================================
   // priority encoder
   logic [5:0]             code;
   always_comb begin
      if (src_lsr)      code = uif_pkg::C_LSR;
      else if (src_to)  code = uif_pkg::C_TO;
      else if (src_rxd) code = uif_pkg::C_RXD;
      else if (src_tx)  code = uif_pkg::C_TX;
      else if (src_msr) code = uif_pkg::C_MSR;
      else if (src_xs)  code = uif_pkg::C_XS;
      else if (src_fl)  code = uif_pkg::C_FLOW;
      else              code = uif_pkg::C_NONE;
   end

   // ======================================================
   // read port and outputs
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) o_rdata <= 8'h00;
      else if (i_rd) begin
         case (i_addr)
            uif_pkg::A_DATA: o_rdata <= (cnt != 5'h00) ? head[7:0] : 8'h00;
            uif_pkg::A_MASK: o_rdata <= mask_reg;
            uif_pkg::A_ISR:  o_rdata <= {fen_reg, fen_reg, code};
            uif_pkg::A_LSR:  o_rdata <= lsr_val;
            uif_pkg::A_MSR:  o_rdata <= i_modem_status;
            default:         o_rdata <= 8'h00;
         endcase
      end
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_int            <= 1'b0;
         o_msr_read       <= 1'b0;
         o_tx_wstrobe     <= 1'b0;
         o_tx_wdata       <= 8'h00;
         o_sleep_en       <= 1'b0;
         o_rx_ready_pin_n <= 1'b1;
         o_tx_ready_pin_n <= 1'b1;
      end else begin
         o_int            <= code != uif_pkg::C_NONE;
         o_msr_read       <= rd_msr;
         o_tx_wstrobe     <= wr_data;
         o_tx_wdata       <= i_wdata;
         o_sleep_en       <= emask[uif_pkg::M_SLEEP];
         o_rx_ready_pin_n <= dma_reg ? !(cnt >= trig || to_flag_reg)
                                     : (cnt == 5'h00);
         o_tx_ready_pin_n <= dma_reg ? i_tx_full : !i_tx_empty;
      end
   end

   // ======================================================
   // checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   sequence s_tx_arm;
      wr_mask && i_wdata[uif_pkg::M_TX] && !mask_reg[uif_pkg::M_TX]
      && i_tx_empty;
   endsequence
   sequence s_tx_clr;
      (rd_isr || wr_data) && !tx_set;
   endsequence

   a_rx_trigger: assert property (
      (fen_reg && src_rxd && !src_lsr && !src_to)
      |-> code == uif_pkg::C_RXD) else $error("rx trigger not reported");
   a_ready_flag: assert property (
      push && !rx_rst |=> lsr_val[0]) else $error("data ready missed");
   a_polled_quiet: assert property (
      (mask_reg[3:0] == 4'h0 && !i_enh_unlock)
      |-> code == uif_pkg::C_NONE) else $error("source while polled");
   a_lsr_global: assert property (
      (cnt != 5'h00 && herr) |-> lsr_val[7])
      else $error("errored head not in global flag");
   a_holding_int: assert property (
      (!fen_reg && emask[0] && cnt != 5'h00 && !src_lsr && !src_to)
      |-> code == uif_pkg::C_RXD) else $error("holding int missing");
   a_tx_arm: assert property (
      s_tx_arm |=> tx_int_reg) else $error("tx arm lost");
   a_tx_clear: assert property (
      s_tx_clr |=> !tx_int_reg) else $error("tx int not cleared");
   a_overrun_int: assert property (
      i_rx_overrun |=> (lsr_int_reg && ovr_reg)
      ##1 (ovr_reg || $past(rd_lsr)))
      else $error("overrun not flagged");
   a_modem_int: assert property (
      (src_msr && !src_lsr && !src_to && !src_rxd && !src_tx)
      |-> code == uif_pkg::C_MSR) else $error("modem int missing");
   a_upper_lock: assert property (
      !i_enh_unlock |=> !o_sleep_en) else $error("sleep while locked");
   a_cts_edge: assert property (
      (i_auto_cts_en && emask[7] && cts_s2 && !cts_d) |=> flow_reg)
      else $error("cts edge lost");
   a_timeout_span: assert property (
      $rose(to_flag_reg) |-> $past(to_cnt) == uif_pkg::TO_BITS)
      else $error("time-out early");
   a_status_bit0: assert property (
      rd_isr |=> o_rdata[0] == !o_int) else $error("bit 0 wrong");
   a_fifo_mirror: assert property (
      rd_isr |=> o_rdata[7:6] == {2{$past(fen_reg)}})
      else $error("fifo mirror wrong");
   a_setup_ignore: assert property (
      (wr_fs && !i_wdata[0]) |=> !fen_reg && $stable(trig_reg))
      else $error("setup bits taken");
   a_rx_reset: assert property (
      rx_rst |=> cnt == 5'h00 ##1 o_rx_ready_pin_n || push)
      else $error("rx reset failed");
endmodule : uif_core
`default_nettype wire

// ==== test/uif_host.sv ====
// host processor model on the register port of one channel
`timescale 1ns/1ps
`default_nettype none
module uif_host (
   input  wire logic       i_clock,
   input  wire logic [7:0] i_rdata,
   output var  logic [2:0] o_addr,
   output var  logic       o_rd,
   output var  logic       o_wr,
   output var  logic [7:0] o_wdata
);
   initial begin
      o_addr  = 3'h0;
      o_rd    = 1'b0;
      o_wr    = 1'b0;
      o_wdata = 8'h00;
   end
   // ======================================================
   // register access, one strobe cycle, released a cycle later
   // setup writes carry bit 0 except where refusal is meant
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge i_clock);
      o_addr  = a;
      o_wdata = d;
      o_wr    = 1'b1;
      @(negedge i_clock);
      o_wr    = 1'b0;
   endtask : wr
   // register reads, data taken after the strobe edge
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(negedge i_clock);
      o_addr = a;
      o_rd   = 1'b1;
      @(negedge i_clock);
      o_rd   = 1'b0;
      d      = i_rdata;
   endtask : rd
endmodule : uif_host
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the interrupt and fifo setup block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       i_clock, i_rst_b, i_rd, i_wr, i_rx_valid, i_rx_overrun;
   logic       i_bit_tick, i_tx_empty, i_tsr_empty, i_xoff_hit, i_rts_n;
   logic       i_enh_unlock, o_int, o_rx_ready, o_tx_wstrobe;
   logic [2:0] i_addr, i_rx_err;
   logic [7:0] i_wdata, o_rdata, i_rx_data, o_tx_wdata, i_modem_status;
   logic [7:0] d;
   logic       ok;
   logic       tx_rst, msr_rd, sleep_en, rx_pin_n, tx_pin_n;
   int         errors, total_checks, acc;
   uif_core uif_core_i (.i_clock(i_clock), .i_rst_b(i_rst_b),
      .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata),
      .o_rdata(o_rdata), .o_int(o_int), .i_enh_unlock(i_enh_unlock),
      .i_auto_cts_en(i_enh_unlock), .i_auto_rts_en(i_enh_unlock),
      .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
      .i_rx_err(i_rx_err), .o_rx_ready(o_rx_ready),
      .i_rx_overrun(i_rx_overrun), .i_bit_tick(i_bit_tick),
      .i_tx_empty(i_tx_empty), .i_tx_full(1'b0),
      .i_tsr_empty(i_tsr_empty), .o_tx_wstrobe(o_tx_wstrobe),
      .o_tx_wdata(o_tx_wdata), .o_tx_fifo_reset(tx_rst),
      .i_modem_status(i_modem_status), .o_msr_read(msr_rd),
      .i_xoff_hit(i_xoff_hit), .i_xon_hit(1'b0), .i_special_hit(1'b0),
      .i_rts_n(i_rts_n), .i_cts_n_pin(i_rts_n), .o_sleep_en(sleep_en),
      .o_rx_ready_pin_n(rx_pin_n), .o_tx_ready_pin_n(tx_pin_n));
   uif_host uif_host_i (.i_clock(i_clock), .i_rdata(o_rdata),
      .o_addr(i_addr), .o_rd(i_rd), .o_wr(i_wr), .o_wdata(i_wdata));
   // ======================================================
   // clock and watchdog
   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end
   initial begin
      #(25 * 20000);
      errors++;
      results();
   end
   // ======================================================
   // shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
      uif_host_i.rd(a, d);
      chk(d, exp);
   endtask : rdchk
   // valid held until taken, withdrawn after eight refused cycles
   task automatic push(input logic [7:0] v, output logic got);
      @(negedge i_clock);
      i_rx_valid = 1'b1;
      i_rx_data  = v;
      got = 1'b0;
      for (int n = 0; n < 8 && !got; n++) begin
         got = o_rx_ready;
         @(negedge i_clock);
      end
      i_rx_valid = 1'b0;
      repeat (4) @(negedge i_clock);
   endtask : push
   task automatic tick(input int n);
      repeat (n) begin
         @(negedge i_clock);
         i_bit_tick = 1'b1;
         @(negedge i_clock);
         i_bit_tick = 1'b0;
      end
      repeat (3) @(negedge i_clock);
   endtask : tick
   task automatic results;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results
   // ======================================================
   // main sequence
   initial begin
      {i_rst_b, i_rx_valid, i_rx_overrun, i_bit_tick, i_xoff_hit} = 5'h00;
      {i_enh_unlock, i_tx_empty, i_tsr_empty, i_rts_n} = 4'hF;
      {i_rx_data, i_rx_err, i_modem_status} = 19'h00000;
      repeat (2) @(negedge i_clock);
      i_rst_b = 1'b1;
      rdchk(uif_pkg::A_ISR, 8'h01);
      rdchk(uif_pkg::A_MASK, uif_pkg::MASK_RST);
      chk({7'h00, o_int}, 8'h00);
      uif_host_i.wr(uif_pkg::A_MASK, 8'h02);
      rdchk(uif_pkg::A_ISR, 8'h02);
      rdchk(uif_pkg::A_ISR, 8'h01);
      uif_host_i.wr(uif_pkg::A_MASK, 8'h21);
      i_tx_empty = 1'b0;
      uif_host_i.wr(uif_pkg::A_ISR, 8'h01);
      rdchk(uif_pkg::A_ISR, 8'hC1);
      uif_host_i.wr(uif_pkg::A_ISR, 8'hC6);
      rdchk(uif_pkg::A_ISR, 8'h01);
      // fill at trigger 14 until refused, then drain in order
      uif_host_i.wr(uif_pkg::A_ISR, 8'hC1);
      acc = 0;
      for (int k = 0; k < 20; k++) begin
         push(8'(k), ok);
         if (ok) acc++;
      end
      chk(8'(acc), 8'(uif_pkg::DEPTH + 2));
      rdchk(uif_pkg::A_ISR, 8'hC4);
      for (int k = 0; k < 18; k++) begin
         rdchk(uif_pkg::A_DATA, 8'(k));
      end
      rdchk(uif_pkg::A_ISR, 8'hC1);
      {i_tx_empty, i_tsr_empty} = 2'b10;
      uif_host_i.rd(uif_pkg::A_LSR, d);
      chk(d & 8'h61, 8'h20);
      // receive fifo reset, self clearing
      push(8'h33, ok);
      uif_host_i.wr(uif_pkg::A_ISR, 8'h07);
      chk({7'h00, tx_rst}, 8'h01);
      uif_host_i.rd(uif_pkg::A_LSR, d);
      chk(d & 8'h01, 8'h00);
      push(8'h44, ok);
      uif_host_i.rd(uif_pkg::A_LSR, d);
      chk(d & 8'h01, 8'h01);
      // time-out at trigger 4 in dma mode: 52 bit ticks, one character held, below trigger
      uif_host_i.wr(uif_pkg::A_ISR, 8'h49);
      tick(51);
      rdchk(uif_pkg::A_ISR, 8'hC1);
      chk({6'h00, rx_pin_n, tx_pin_n}, 8'h02);
      tick(1);
      rdchk(uif_pkg::A_ISR, 8'hCC);
      chk({6'h00, rx_pin_n, tx_pin_n}, 8'h00);
      rdchk(uif_pkg::A_DATA, 8'h44);
      rdchk(uif_pkg::A_ISR, 8'hC1);
      // line status outranks modem status
      uif_host_i.wr(uif_pkg::A_MASK, 8'h0C);
      i_modem_status = 8'h01;
      @(negedge i_clock);
      i_rx_overrun = 1'b1;
      @(negedge i_clock);
      i_rx_overrun = 1'b0;
      rdchk(uif_pkg::A_ISR, 8'hC6);
      uif_host_i.rd(uif_pkg::A_LSR, d);
      chk(d & 8'h02, 8'h02);
      rdchk(uif_pkg::A_ISR, 8'hC0);
      // errored character: tagged at once, interrupt only when read out
      i_rx_err = 3'b100;
      push(8'h55, ok);
      i_rx_err = 3'b000;
      uif_host_i.rd(uif_pkg::A_LSR, d);
      chk(d & 8'h9C, 8'h90);
      rdchk(uif_pkg::A_ISR, 8'hC0);
      rdchk(uif_pkg::A_DATA, 8'h55);
      rdchk(uif_pkg::A_ISR, 8'hC6);
      uif_host_i.rd(uif_pkg::A_LSR, d);
      chk(d & 8'h9C, 8'h00);
      rdchk(uif_pkg::A_ISR, 8'hC0);
      uif_host_i.rd(uif_pkg::A_MSR, d);
      chk(d, 8'h01);
      chk({7'h00, msr_rd}, 8'h01);
      i_modem_status = 8'h00;
      rdchk(uif_pkg::A_ISR, 8'hC1);
      // xoff match, cleared by status read
      uif_host_i.wr(uif_pkg::A_MASK, 8'h20);
      @(negedge i_clock);
      i_xoff_hit = 1'b1;
      @(negedge i_clock);
      i_xoff_hit = 1'b0;
      rdchk(uif_pkg::A_ISR, 8'hD0);
      rdchk(uif_pkg::A_ISR, 8'hC1);
      // rising request and clear to send, sleep enable while unlocked
      uif_host_i.wr(uif_pkg::A_MASK, 8'hD0);
      @(negedge i_clock);
      i_rts_n = 1'b0;
      @(negedge i_clock);
      i_rts_n = 1'b1;
      repeat (4) @(negedge i_clock);
      chk({7'h00, sleep_en}, 8'h01);
      rdchk(uif_pkg::A_ISR, 8'hE0);
      uif_host_i.rd(uif_pkg::A_MSR, d);
      rdchk(uif_pkg::A_ISR, 8'hC1);
      i_enh_unlock = 1'b0;
      repeat (2) @(negedge i_clock);
      chk({7'h00, sleep_en}, 8'h00);
      rdchk(uif_pkg::A_ISR, 8'hC1);
      uif_host_i.wr(uif_pkg::A_DATA, 8'h5A);
      chk({7'h00, o_tx_wstrobe}, 8'h01);
      chk(o_tx_wdata, 8'h5A);
      results();
   end
endmodule : testbench
`default_nettype wire
